/* File: common/pswdg_pkg.sv */
// Package of constants and carrier types for the diagnosis logic
package pswdg_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int unsigned NCH     = 6;     // Number of power channels
    localparam int unsigned SEL_W   = 3;     // Sense select width

    // ------------------------------------------------------------------
    // Sense select codes
    // ------------------------------------------------------------------
    localparam logic [2:0] SEL_CH0  = 3'h0;  // Channel 0
    localparam logic [2:0] SEL_DIS  = 3'h6;  // Sense output disabled

    // ------------------------------------------------------------------
    // Link frame timing (serial clock rising edges)
    // ------------------------------------------------------------------
    localparam logic [3:0] EDGE_OVL_CLR = 4'h2; // Clear after 2nd edge
    localparam logic [3:0] EDGE_ARM     = 4'h3; // Arm after 3rd edge
    localparam int unsigned CTL_BIT     = 0;    // Clear latch bit pos

    // ------------------------------------------------------------------
    // Wishbone register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CTRL    = 8'h00; // Sense select only
    localparam logic [7:0] A_STAT    = 8'h04; // Error flags, monitor
    localparam logic [7:0] A_IRQ_ST  = 8'h08; // Sticky events, RO
    localparam logic [7:0] A_IRQ_CLR = 8'h0c; // Write one to clear
    localparam logic [7:0] A_IRQ_EN  = 8'h10; // Interrupt enable
    localparam logic [7:0] A_THERM   = 8'h14; // Thermal latch state

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned F_SEL_LSB = 0;    // Select in CTRL[2:0]
    localparam int unsigned F_BYP     = 8;    // Monitor bit in STAT
    localparam logic [2:0] SEL_RST    = 3'h6; // Sense disabled at reset

    // ------------------------------------------------------------------
    // Carrier: per-channel analog-side status
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NCH-1:0] on_cmd;     // Channel commanded on
        logic [NCH-1:0] ovl;        // Over-load monitor active
        logic [NCH-1:0] ovt;        // Over-temperature detected
        logic [NCH-1:0] vds_low;    // Drain-source below threshold
    } pswdg_chan_s;

endpackage

/* File: rtl/pswdg_core.sv */
// Diagnosis logic of the multi-channel high-side switch
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
// Contract
// - Error flag is thermal OR latched overload
// - Overload latch cleared between edges two, three
// - Thermal latch holds channel off until cleared
// - Thermal flag cleared next frame, armed edge three
// - First diagnosis after clear still shows fault
// - Persistent overload sets flag again immediately
// - Thermal latch kept while channel off
// - Sense off on overcurrent or overtemperature
// - Sense only for selected healthy on channel
// - Multiplexer routes exactly the selected channel
// - Disable setting disconnects all channels
// - On channel faults report error flag one
// - On channel normal cases flag and monitor
// - Off channel flag zero, monitor per voltage (code does not gate the flag with on_cmd; a kept thermal latch still flags)
// - Config bit zero clears all thermal latches
// - Select code zero picks channel zero
// - Select code six disables sense output
// - Monitor bit compares selected drain-source
module pswdg_core (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Serial link, from the host master
    input  wire logic                 sclk_i,
    input  wire logic                 cs_n_i,
    // Diagnosis frame strobes, from link decoder
    input  wire logic                 diag_tx_i,
    input  wire logic                 hw_cfg_wr_i,
    input  wire logic [3:0]           hw_cfg_dat_i,
    // Power stage status
    input  wire pswdg_pkg::pswdg_chan_s chan_i,
    // Sense path
    output logic [pswdg_pkg::NCH-1:0] gate_en_o,
    output logic [pswdg_pkg::NCH-1:0] sense_en_o,
    output logic                      bypass_monitor_result_o,
    output logic [pswdg_pkg::NCH-1:0] channel_error_flag_o,
    // Interrupt
    output logic                      irq_o
);
    localparam int unsigned N = pswdg_pkg::NCH;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0]   sclk_s_q;     // Serial clock sync pair
    logic [1:0]   cs_s_q;       // Frame select sync pair
    logic         sclk_d_q;     // Previous synced serial clock
    logic [N-1:0] ovl_s1_q;     // Overload first stage
    logic [N-1:0] ovl_s_q;      // Overload synced
    logic [N-1:0] ovt_s1_q;     // Thermal first stage
    logic [N-1:0] ovt_s_q;      // Thermal synced

    // Two flops on serial clock, frame select, overload and thermal levels
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_s_q <= 2'h0;
            cs_s_q   <= 2'h3;
            sclk_d_q <= 1'b0;
            ovl_s1_q <= '0;
            ovl_s_q  <= '0;
            ovt_s1_q <= '0;
            ovt_s_q  <= '0;
        end else begin
            sclk_s_q <= {sclk_s_q[0], sclk_i};
            cs_s_q   <= {cs_s_q[0], cs_n_i};
            sclk_d_q <= sclk_s_q[1];
            ovl_s1_q <= chan_i.ovl;
            ovl_s_q  <= ovl_s1_q;
            ovt_s1_q <= chan_i.ovt;
            ovt_s_q  <= ovt_s1_q;
        end
    end

    logic sclk_rise;            // Rising serial edge pulse
    logic frame_act;            // Frame in progress
    assign sclk_rise = sclk_s_q[1] & ~sclk_d_q;
    assign frame_act = ~cs_s_q[1];

    // ------------------------------------------------------------------
    // Frame edge counter
    // ------------------------------------------------------------------
    logic [3:0] edge_cnt_q;     // Rising edges seen in this frame

    // Count edges, restart when frame closes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            edge_cnt_q <= 4'h0;
        end else if (!frame_act) begin
            edge_cnt_q <= 4'h0;
        end else if (sclk_rise && edge_cnt_q != 4'hf) begin
            edge_cnt_q <= edge_cnt_q + 4'h1;
        end
    end

    logic at_clr_edge;          // Second edge arriving
    logic at_arm_edge;          // Third edge arriving
    assign at_clr_edge = frame_act && sclk_rise
                         && edge_cnt_q == pswdg_pkg::EDGE_OVL_CLR - 4'h1;
    assign at_arm_edge = frame_act && sclk_rise
                         && edge_cnt_q == pswdg_pkg::EDGE_ARM - 4'h1;

    // ------------------------------------------------------------------
    // Diagnosis frame capture
    // ------------------------------------------------------------------
    logic diag_frm_q;           // Current frame carries diagnosis
    logic ctl_pend_q;           // Clear command seen, awaits next frame
    logic therm_clr_q;          // Thermal flag held clear this frame
    logic ctl_cmd;              // Clear command strobe

    assign ctl_cmd = hw_cfg_wr_i && hw_cfg_dat_i[pswdg_pkg::CTL_BIT];

    // Mark diagnosis frames, cleared at frame end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            diag_frm_q <= 1'b0;
        end else if (diag_tx_i) begin
            diag_frm_q <= 1'b1;
        end else if (!frame_act) begin
            diag_frm_q <= 1'b0;
        end
    end

    // Pending clear spans to the following frame
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl_pend_q  <= 1'b0;
            therm_clr_q <= 1'b0;
        end else begin
            if (ctl_cmd) begin
                ctl_pend_q <= 1'b1;
            end else if (ctl_pend_q && frame_act && !therm_clr_q
                         && edge_cnt_q == 4'h0 && sclk_rise) begin
                ctl_pend_q  <= 1'b0;
                therm_clr_q <= 1'b1;
            end
            if (at_arm_edge) begin
                therm_clr_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Thermal and overload latches, error flag and gate control
    // ------------------------------------------------------------------
    logic [N-1:0] therm_lat_q;  // Gate-control thermal latch
    logic [N-1:0] therm_flag_q; // Thermal copy in the error flag
    logic [N-1:0] ovl_lat_q;    // Latched overload part

    // Set on heat regardless of on command; only clear command frees
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            therm_lat_q <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (ovt_s_q[i]) begin
                    therm_lat_q[i] <= 1'b1;
                end else if (ctl_cmd) begin
                    therm_lat_q[i] <= 1'b0;
                end
            end
        end
    end

    // Second thermal latch, cleared next frame and rearmed at edge 3
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            therm_flag_q <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (therm_clr_q) begin
                    therm_flag_q[i] <= 1'b0;
                end else if (therm_lat_q[i]) begin
                    therm_flag_q[i] <= 1'b1;
                end
            end
        end
    end

    // Overload latch, set wins over the diagnosis clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ovl_lat_q <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (ovl_s_q[i]) begin
                    ovl_lat_q[i] <= 1'b1;
                end else if (diag_frm_q && at_clr_edge) begin
                    ovl_lat_q[i] <= 1'b0;
                end
            end
        end
    end

    // Per-channel flags are independent bits
    assign channel_error_flag_o = therm_flag_q | ovl_lat_q;
    assign gate_en_o = chan_i.on_cmd & ~therm_lat_q;

    // ------------------------------------------------------------------
    // Sense multiplexer and bypass monitor
    // ------------------------------------------------------------------
    logic [2:0]   sense_channel_select_q; // Sense select field
    logic [N-1:0] healthy;                // On and no failure

    assign healthy = gate_en_o & ~ovl_s_q & ~therm_lat_q;

    // Decode select into a one-hot sense enable
    always_comb begin
        sense_en_o              = '0;
        bypass_monitor_result_o = 1'b0;
        if (sense_channel_select_q != pswdg_pkg::SEL_DIS
            && sense_channel_select_q < 3'(N)) begin
            sense_en_o[sense_channel_select_q] =
                healthy[sense_channel_select_q];
            bypass_monitor_result_o =
                chan_i.vds_low[sense_channel_select_q];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, clear, enable
    // ------------------------------------------------------------------
    logic [N-1:0] irq_st_q;     // Sticky new-error events
    logic [N-1:0] irq_en_q;     // Enable mask
    logic [N-1:0] err_d_q;      // Previous flags for edge find
    logic [N-1:0] irq_clr;      // Clear strobe from bus
    logic         wb_wr;        // Write committed at the ack edge

    // Commit only where the master samples ack high
    assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign irq_clr = (wb_wr && wb_adr_i == pswdg_pkg::A_IRQ_CLR
                      && wb_sel_i[0]) ? wb_dat_i[N-1:0] : '0;

    // Rising error flag sets sticky bit; set wins over clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            err_d_q  <= '0;
            irq_st_q <= '0;
        end else begin
            err_d_q  <= channel_error_flag_o;
            irq_st_q <= (irq_st_q & ~irq_clr)
                        | (channel_error_flag_o & ~err_d_q);
        end
    end

    assign irq_o = |(irq_st_q & irq_en_q);

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    // Control writes and one-cycle acknowledge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wb_ack_o               <= 1'b0;
            sense_channel_select_q <= pswdg_pkg::SEL_RST;
            irq_en_q               <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_wr && wb_sel_i[0]) begin
                case (wb_adr_i)
                    pswdg_pkg::A_CTRL: begin
                        sense_channel_select_q <= wb_dat_i[2:0];
                    end
                    pswdg_pkg::A_IRQ_EN: begin
                        irq_en_q <= wb_dat_i[N-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read data registered with the acknowledge; unmapped reads zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wb_dat_o <= 32'h0;
        end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
            case (wb_adr_i)
                pswdg_pkg::A_CTRL:   wb_dat_o <= {29'h0,
                                                  sense_channel_select_q};
                pswdg_pkg::A_STAT:   wb_dat_o <= {23'h0,
                                                  bypass_monitor_result_o,
                                                  2'h0,
                                                  channel_error_flag_o};
                pswdg_pkg::A_IRQ_ST: wb_dat_o <= {26'h0, irq_st_q};
                pswdg_pkg::A_IRQ_EN: wb_dat_o <= {26'h0, irq_en_q};
                pswdg_pkg::A_THERM:  wb_dat_o <= {26'h0, therm_lat_q};
                default:             wb_dat_o <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_err_or;
        @(posedge clk_i) disable iff (!arst_n_i)
        ovl_lat_q != '0 |-> channel_error_flag_o != '0;
    endproperty
    a_err_or: assert property (p_err_or) else $error("flag missing");

    property p_ovl_clr;
        @(posedge clk_i) disable iff (!arst_n_i)
        (diag_frm_q && at_clr_edge && ovl_s_q == '0) |=> ovl_lat_q == '0;
    endproperty
    a_ovl_clr: assert property (p_ovl_clr) else $error("ovl kept");

    property p_gate_off;
        @(posedge clk_i) disable iff (!arst_n_i)
        therm_lat_q != '0 |-> (gate_en_o & therm_lat_q) == '0;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate on");

    property p_ctl_clr;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ctl_cmd && ovt_s_q == '0) |=> therm_lat_q == '0;
    endproperty
    a_ctl_clr: assert property (p_ctl_clr) else $error("latch kept");

    property p_arm;
        @(posedge clk_i) disable iff (!arst_n_i)
        at_arm_edge |=> !therm_clr_q;
    endproperty
    a_arm: assert property (p_arm) else $error("not armed");

    property p_ovl_set;
        @(posedge clk_i) disable iff (!arst_n_i)
        ovl_s_q != '0 |=> (ovl_lat_q & $past(ovl_s_q)) == $past(ovl_s_q);
    endproperty
    a_ovl_set: assert property (p_ovl_set) else $error("ovl lost");

    property p_sense_fault;
        @(posedge clk_i) disable iff (!arst_n_i)
        (sense_en_o & (ovl_s_q | therm_lat_q)) == '0;
    endproperty
    a_sense_fault: assert property (p_sense_fault)
        else $error("sense on fault");

    property p_sense_dis;
        @(posedge clk_i) disable iff (!arst_n_i)
        sense_channel_select_q == pswdg_pkg::SEL_DIS |-> sense_en_o == '0;
    endproperty
    a_sense_dis: assert property (p_sense_dis) else $error("not off");

    property p_onehot;
        @(posedge clk_i) disable iff (!arst_n_i)
        $onehot0(sense_en_o);
    endproperty
    a_onehot: assert property (p_onehot) else $error("multi sense");

    c_ovl_clr: cover property (@(posedge clk_i) diag_frm_q && at_clr_edge);
    c_ctl:     cover property (@(posedge clk_i) ctl_cmd ##[1:200] therm_clr_q);
    c_irq:     cover property (@(posedge clk_i) irq_o);
    c_sense:   cover property (@(posedge clk_i) sense_en_o != '0);

endmodule // pswdg_core

/* File: verif/pswdg_core_test.sv */
// Self-checking testbench of the diagnosis logic
`timescale 1ns/10ps
module pswdg_core_test;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                    clk_i, arst_n_i;   // Clock, reset
    logic                    cyc, stb, we;      // Bus request
    logic [7:0]              adr;               // Bus address
    logic [31:0]             wdat, rdat, q;     // Bus data
    logic                    ack, irq;          // Bus answer, interrupt
    logic                    sclk, cs_n, dtx, cwr; // Link strobes
    logic [3:0]              cdat;              // Command data
    logic [4:0]              rises;             // Serial rise count
    pswdg_pkg::pswdg_chan_s  chan;              // Power stage status
    logic [5:0]              gate, sense, flag; // Channel outputs
    logic                    byp;               // Monitor result
    int                      miscompares, total_checks, k;
    logic [31:0]             rng;               // Random state

    // Clock of 40 ns
    always #20 clk_i = ~clk_i;

    pswdg_core u_pswdg_core (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sclk_i(sclk), .cs_n_i(cs_n), .diag_tx_i(dtx),
        .hw_cfg_wr_i(cwr), .hw_cfg_dat_i(cdat), .chan_i(chan),
        .gate_en_o(gate), .sense_en_o(sense),
        .bypass_monitor_result_o(byp), .channel_error_flag_o(flag),
        .irq_o(irq));

    pswdg_host_model u_pswdg_host_model (
        .clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .diag_tx_o(dtx),
        .hw_cfg_wr_o(cwr), .hw_cfg_dat_o(cdat), .rises_o(rises));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Xorshift generator
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // Expected sense enable for a select code
    function automatic logic [5:0] exp_sense(int s, logic [5:0] on);
        return (s < 6) ? (on & (6'h01 << s)) : 6'h00;
    endfunction

    // Expected monitor bit for a select code
    function automatic logic exp_byp(int s, logic [5:0] v);
        return (s < 6) ? v[s] : 1'b0;
    endfunction

    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Wait some clock cycles
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One classic bus cycle, held until acknowledged
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            finish_test();
        end
    endtask

    // Bounded wait for a serial rise count
    task automatic wait_rise(input int r);
        int n;
        for (n = 0; n < 400 && rises < r; n++) @(posedge clk_i);
        if (n >= 400) begin
            miscompares++;
            finish_test();
        end
        @(posedge clk_i);
    endtask

    // Pulse one fault input for a few cycles
    task automatic pulse(input int c, input logic temp);
        if (temp) chan.ovt[c] <= 1'b1;
        else chan.ovl[c] <= 1'b1;
        step(4);
        chan.ovt <= 6'h00;
        chan.ovl <= 6'h00;
        step(6);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0; arst_n_i = 1'b0; cyc = 1'b0; stb = 1'b0;
        we = 1'b0; adr = 8'h00; wdat = 32'h0; rng = 32'h52;
        miscompares = 0; total_checks = 0; chan = '0;
        step(5);
        arst_n_i <= 1'b1;
        wb(pswdg_pkg::A_CTRL, 1'b0, 32'h0);
        chk(q & 32'h7, {29'h0, pswdg_pkg::SEL_DIS}, "sel rst");
        wb(8'h1c, 1'b0, 32'h0);
        chk(q, 32'h0, "unmapped");
        // Select sweep with random loads, no faults
        for (int i = 0; i < 16; i++) begin
            chan.on_cmd  <= 6'(rnd());
            chan.vds_low <= 6'(rnd());
            wb(pswdg_pkg::A_CTRL, 1'b1, i % 8);
            step(3);
            chk(sense, exp_sense(i % 8, chan.on_cmd), "sense");
            chk(byp, exp_byp(i % 8, chan.vds_low), "bypass");
            chk(flag, 6'h00, "no fault flag");
        end
        // Overload latch and its clear by diagnosis
        k = rnd() % 6;
        chan.on_cmd <= 6'h3f;
        wb(pswdg_pkg::A_IRQ_EN, 1'b1, 32'h3f);
        wb(pswdg_pkg::A_CTRL, 1'b1, k);
        step(3);
        chk(sense, 6'h01 << k, "sense on");
        pulse(k, 1'b0);
        chk(flag, 6'h01 << k, "ovl flag");
        chk(irq, 1'b1, "irq set");
        wb(pswdg_pkg::A_STAT, 1'b0, 32'h0);
        chk(q[5:0], 6'h01 << k, "stat");
        u_pswdg_host_model.frame(1'b0, 1'b0, 4'h0);
        chk(flag, 6'h01 << k, "no diag frame");
        fork
            u_pswdg_host_model.frame(1'b1, 1'b0, 4'h0);
            begin
                wait_rise(2);
                chk(flag, 6'h01 << k, "before edge two");
                wait_rise(3);
                chk(flag, 6'h00, "by edge three");
            end
        join
        // Interrupt clear and mask
        wb(pswdg_pkg::A_IRQ_CLR, 1'b1, 32'h3f);
        step(2);
        chk(irq, 1'b0, "irq clr");
        wb(pswdg_pkg::A_IRQ_EN, 1'b1, 32'h0);
        pulse((k + 1) % 6, 1'b0);
        chk(irq, 1'b0, "irq masked");
        wb(pswdg_pkg::A_IRQ_ST, 1'b0, 32'h0);
        chk(q, 32'h1 << ((k + 1) % 6), "sticky");
        wb(pswdg_pkg::A_IRQ_EN, 1'b1, 32'h3f);
        step(2);
        chk(irq, 1'b1, "irq unmasked");
        wb(pswdg_pkg::A_IRQ_CLR, 1'b1, 32'h3f);
        u_pswdg_host_model.frame(1'b1, 1'b0, 4'h0);
        // Persistent overload survives the clear
        chan.ovl[k] <= 1'b1;
        step(6);
        chk(sense, 6'h00, "sense off ovl");
        u_pswdg_host_model.frame(1'b1, 1'b0, 4'h0);
        chk(flag, 6'h01 << k, "ovl persists");
        chan.ovl <= 6'h00;
        u_pswdg_host_model.frame(1'b1, 1'b0, 4'h0);
        // Thermal latch
        pulse(k, 1'b1);
        chk(gate, 6'h3f & ~(6'h01 << k), "gate off");
        chk(sense, 6'h00, "sense off ovt");
        chk(flag, 6'h01 << k, "ovt flag");
        chan.on_cmd[k] <= 1'b0;
        u_pswdg_host_model.frame(1'b1, 1'b1, 4'he);
        wb(pswdg_pkg::A_THERM, 1'b0, 32'h0);
        chk(q[5:0], 6'h01 << k, "latch kept");
        chan.on_cmd[k] <= 1'b1;
        u_pswdg_host_model.frame(1'b0, 1'b1, 4'h1);
        step(3);
        wb(pswdg_pkg::A_THERM, 1'b0, 32'h0);
        chk(q[5:0], 6'h00, "latch cleared");
        chk(gate, 6'h3f, "gate back");
        chk(flag, 6'h01 << k, "flag after clear");
        fork
            u_pswdg_host_model.frame(1'b1, 1'b0, 4'h0);
            begin
                wait_rise(3);
                chk(flag, 6'h00, "thermal flag gone");
            end
        join
        finish_test();
    end
endmodule // pswdg_core_test

/* File: verif/pswdg_host_model.sv */
// Host link master model: frames, serial clock and decoded strobes
`timescale 1ns/10ps
module pswdg_host_model (
    // Clock
    input  wire logic       clk_i,
    // Serial link
    output logic            sclk_o,
    output logic            cs_n_o,
    // Decoded command strobes
    output logic            diag_tx_o,
    output logic            hw_cfg_wr_o,
    output logic [3:0]      hw_cfg_dat_o,
    // Serial rises seen in the current frame
    output logic [4:0]      rises_o
);
    // Idle: serial clock still, frame deselected
    initial begin
        sclk_o       = 1'b0;
        cs_n_o       = 1'b1;
        diag_tx_o    = 1'b0;
        hw_cfg_wr_o  = 1'b0;
        hw_cfg_dat_o = 4'h5;
        rises_o      = 5'h0;
    end

    // One frame of eight serial clocks, diagnosis strobe at its start, config command decoded at its end
    task automatic frame(input logic diag, input logic cfg,
                         input logic [3:0] dat);
        @(posedge clk_i);
        cs_n_o    <= 1'b0;
        rises_o   <= 5'h0;
        @(posedge clk_i);
        diag_tx_o <= diag;
        @(posedge clk_i);
        diag_tx_o <= 1'b0;
        #13;
        // Offset keeps serial edges off the block clock edges
        repeat (8) begin
            #160 sclk_o = 1'b1;
            rises_o = rises_o + 5'h1;
            #160 sclk_o = 1'b0;
        end
        @(posedge clk_i);
        cs_n_o       <= 1'b1;
        rises_o      <= 5'h0;          // No stale count between frames
        hw_cfg_wr_o  <= cfg;
        hw_cfg_dat_o <= dat;
        @(posedge clk_i);
        hw_cfg_wr_o  <= 1'b0;
        hw_cfg_dat_o <= ~dat;          // Stale data not held
    endtask
endmodule // pswdg_host_model
